// ===== logic/acr_converter_ctrl.sv
// Purpose: control, status and result registers of a 10-bit successive-approximation converter
// Assumes: core result and trigger flags are on CLK_I and stable when sampled
// Notes: every input is on the system clock, so none passes a synchroniser
// Behaviour
// - result is 10-bit unsigned, input times 1024 over reference, 0x000 to 0x3FF.
// - reference field bits 7:6: external, supply, reserved, internal 1.1V.
// - reference or channel writes during a conversion apply after it completes.
// - left-align bit 5 changes the presented result immediately, even mid-conversion.
// - bit 4 of the selection register always reads zero.
// - channel field: 0-7 inputs, 8-13 reserved, 14 bandgap, 15 ground.
// - enable one powers the converter; zero turns off and aborts a conversion.
// - start bit begins a conversion; free running needs it only first time.
// - first conversion after enabling takes 25 converter cycles, later ones 13.
// - start bit reads one while converting; writing zero does nothing.
// - with auto-trigger on, rising edge of the selected trigger starts a conversion.
// - completion flag bit 4 sets when a conversion finishes, whether or not the result updates.
// - interrupt requested while flag, interrupt enable and global enable are set.
// - flag clears on vector acknowledge or a written one.
// - divider field: codes 0,1 divide by 2; 2 to 7 by 4 up to 128.
// - low-byte read blocks result updates until the high byte is read.
// - right align puts bits 9:8 high, 7:0 low; left align 9:2 high, 1:0 low.
// - trigger source zero is free running and never makes a trigger edge.
// - free running restarts at completion; channel change lands one conversion later.

`timescale 1ns/1ps

module acr_converter_ctrl
	import acr_pkg::*;
#(
	parameter int RESULT_W = 10
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [RESULT_W-1:0] CORE_RESULT_I,
	input wire logic [6:0] TRIG_I,
	input wire logic GLOBAL_IRQ_EN_I,
	input wire logic IRQ_ACK_I,
	output logic [7:0] RDATA_O,
	output logic IRQ_REQ_O,
	output logic POWER_O,
	output logic BUSY_O,
	output logic SAMPLE_O,
	output logic CONV_TICK_O,
	output logic INT_REF_ON_O,
	output logic [1:0] REF_SEL_O,
	output logic [3:0] CHAN_SEL_O
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	generate
		if (RESULT_W != 10) begin : g_bad_width
			$error("result width must be 10");
		end
		// completion is detected on the tick that counts down the last cycle
		if (ACR_LAST_CYCLE != 5'h01) begin : g_bad_last
			$error("last cycle count must be one");
		end
		if (ACR_NORMAL_CYCLES >= ACR_FIRST_CYCLES) begin : g_bad_counts
			$error("first conversion must be the longer one");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// divider terminal count: codes below the minimum share divide-by-2
	function automatic logic [6:0] div_last(input logic [2:0] code);
		logic [2:0] shift;
		logic [7:0] span;
		shift = (code < ACR_DIV_MIN_SHIFT) ? ACR_DIV_MIN_SHIFT : code;
		span = (8'h01 << shift) - 8'h01;
		return span[6:0];
	endfunction

	// high byte in [15:8], low byte in [7:0]; unused positions read zero
	function automatic logic [15:0] present(input logic [9:0] res, input logic left);
		logic [15:0] word;
		word = 16'h0000;
		if (left) begin
			word = {res, 6'h00};
		end else begin
			word = {6'h00, res};
		end
		return word;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	acr_state_t s_reg;
	acr_state_t s_next;

	logic wr_ctrl;
	logic wr_ctrl_b;
	logic wr_sel;
	logic rd_low;
	logic rd_high;
	logic rd_ctrl;
	logic rd_ctrl_b;
	logic rd_sel;
	logic soft_start;
	logic trig_level;
	logic trig_edge;
	logic tick;
	logic done;
	logic restart;
	logic do_start;
	logic [15:0] shown;
	acr_sel_t written_sel;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rdata = ACR_READ_IDLE;
		s_next.sample = 1'b0;
		s_next.conv_tick = 1'b0;
		do_start = 1'b0;
		restart = 1'b0;

		wr_ctrl = WR_I && (ADDR_I == ACR_ADDR_CONTROL);
		wr_ctrl_b = WR_I && (ADDR_I == ACR_ADDR_CONTROL_B);
		wr_sel = WR_I && (ADDR_I == ACR_ADDR_SELECT);
		rd_low = RD_I && (ADDR_I == ACR_ADDR_RESULT_LOW);
		rd_high = RD_I && (ADDR_I == ACR_ADDR_RESULT_HIGH);
		rd_ctrl = RD_I && (ADDR_I == ACR_ADDR_CONTROL);
		rd_ctrl_b = RD_I && (ADDR_I == ACR_ADDR_CONTROL_B);
		rd_sel = RD_I && (ADDR_I == ACR_ADDR_SELECT);

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		written_sel.ref_sel = WDATA_I[ACR_SEL_REF_MSB:ACR_SEL_REF_LSB];
		written_sel.chan_sel = WDATA_I[ACR_SEL_CHAN_MSB:ACR_SEL_CHAN_LSB];
		if (wr_sel) begin
			s_next.sel_reg = written_sel;
			s_next.left_align = WDATA_I[ACR_SEL_ALIGN_BIT];
		end
		if (wr_ctrl_b) begin
			s_next.trig_src = WDATA_I[ACR_TRIG_MSB:ACR_TRIG_LSB];
		end
		if (wr_ctrl) begin
			s_next.enable = WDATA_I[ACR_CTRL_ENABLE_BIT];
			s_next.auto_trig = WDATA_I[ACR_CTRL_AUTO_BIT];
			s_next.irq_en = WDATA_I[ACR_CTRL_IRQ_EN_BIT];
			s_next.div_code = WDATA_I[ACR_CTRL_DIV_MSB:ACR_CTRL_DIV_LSB];
			if (WDATA_I[ACR_CTRL_ENABLE_BIT] && !s_reg.enable) begin
				s_next.first_pending = 1'b1;
			end
		end
		// writing zero to start has no effect
		soft_start = wr_ctrl && WDATA_I[ACR_CTRL_START_BIT];

		// a read-modify-write that carries the flag back as one clears it
		if ((wr_ctrl && WDATA_I[ACR_CTRL_FLAG_BIT]) || IRQ_ACK_I) begin
			s_next.flag = 1'b0;
		end

		// ------------------------------------------------------------
		// trigger edge
		// ------------------------------------------------------------
		// source zero has no edge, so choosing it cannot fire a start
		if (s_reg.trig_src == ACR_TRIG_FREE_RUN) begin
			trig_level = 1'b0;
		end else begin
			trig_level = TRIG_I[s_reg.trig_src - 3'h1];
		end
		s_next.trig_prev = trig_level;
		// switching from a low source to one that is already high counts as an edge
		trig_edge = s_reg.auto_trig && trig_level && !s_reg.trig_prev;

		// ------------------------------------------------------------
		// converter clock divider
		// ------------------------------------------------------------
		tick = (s_reg.phase == ACR_BUSY) && (s_reg.presc == div_last(s_reg.div_code));
		done = tick && (s_reg.cycles_left == ACR_LAST_CYCLE);
		if (s_reg.phase == ACR_BUSY) begin
			s_next.presc = tick ? 7'h00 : s_reg.presc + 7'h01;
			s_next.conv_tick = tick;
			if (tick) begin
				s_next.cycles_left = s_reg.cycles_left - 5'h01;
			end
		end else begin
			s_next.presc = 7'h00;
		end

		// ------------------------------------------------------------
		// conversion sequence
		// ------------------------------------------------------------
		unique case (s_reg.phase)
			ACR_OFF: begin
				if (s_next.enable) begin
					s_next.phase = ACR_IDLE;
					// start in the same write as enable is a first conversion
					do_start = soft_start;
				end
			end
			ACR_IDLE: begin
				if (!s_next.enable) begin
					s_next.phase = ACR_OFF;
				end else begin
					do_start = soft_start || trig_edge;
				end
			end
			ACR_BUSY: begin
				if (!s_next.enable) begin
					// turning off drops the running conversion, no result, no flag
					s_next.phase = ACR_OFF;
					s_next.cycles_left = 5'h00;
				end else if (done) begin
					// a locked pair keeps the old value; the new result is lost
					if (!s_reg.locked) begin
						s_next.result = CORE_RESULT_I;
					end
					s_next.flag = 1'b1;
					s_next.phase = ACR_IDLE;
					restart = s_reg.auto_trig && (s_reg.trig_src == ACR_TRIG_FREE_RUN);
				end
			end
			default: begin
				s_next.phase = ACR_OFF;
			end
		endcase

		// ------------------------------------------------------------
		// selection hand-over
		// ------------------------------------------------------------
		if (restart) begin
			// the follow-on conversion uses what was pending before this one ended
			s_next.conv_sel = s_reg.pend_sel;
			s_next.pend_sel = s_next.sel_reg;
			s_next.phase = ACR_BUSY;
			s_next.cycles_left = s_next.first_pending ? ACR_FIRST_CYCLES : ACR_NORMAL_CYCLES;
			s_next.first_pending = 1'b0;
			s_next.presc = 7'h00;
			s_next.sample = 1'b1;
		end else if (do_start) begin
			s_next.conv_sel = s_next.sel_reg;
			s_next.pend_sel = s_next.sel_reg;
			s_next.phase = ACR_BUSY;
			s_next.cycles_left = s_next.first_pending ? ACR_FIRST_CYCLES : ACR_NORMAL_CYCLES;
			s_next.first_pending = 1'b0;
			s_next.presc = 7'h00;
			s_next.sample = 1'b1;
		end else if (s_next.phase != ACR_BUSY) begin
			// outside a conversion the selection follows the register
			s_next.conv_sel = s_next.sel_reg;
			s_next.pend_sel = s_next.sel_reg;
		end
		s_next.int_ref_on = s_next.enable && (s_next.conv_sel.ref_sel == ACR_REF_INTERNAL);

		// ------------------------------------------------------------
		// result lock and read data
		// ------------------------------------------------------------
		if (rd_low) begin
			s_next.locked = 1'b1;
		end
		if (rd_high) begin
			s_next.locked = 1'b0;
		end
		// alignment is applied on the way out so a change shows at once
		shown = present(s_reg.result, s_reg.left_align);
		if (rd_low) begin
			s_next.rdata = shown[7:0];
		end else if (rd_high) begin
			s_next.rdata = shown[15:8];
		end else if (rd_ctrl) begin
			s_next.rdata = {s_reg.enable, (s_reg.phase == ACR_BUSY), s_reg.auto_trig,
				s_reg.flag, s_reg.irq_en, s_reg.div_code};
		end else if (rd_ctrl_b) begin
			s_next.rdata = {5'h00, s_reg.trig_src};
		end else if (rd_sel) begin
			s_next.rdata = {s_reg.sel_reg.ref_sel, s_reg.left_align, 1'b0,
				s_reg.sel_reg.chan_sel};
		end

		// ------------------------------------------------------------
		// interrupt request
		// ------------------------------------------------------------
		s_next.irq_req = s_next.flag && s_next.irq_en && GLOBAL_IRQ_EN_I;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s_reg.phase <= ACR_OFF;
			s_reg.sel_reg <= {ACR_RESET_SELECT[ACR_SEL_REF_MSB:ACR_SEL_REF_LSB],
				ACR_RESET_SELECT[ACR_SEL_CHAN_MSB:ACR_SEL_CHAN_LSB]};
			s_reg.left_align <= ACR_RESET_SELECT[ACR_SEL_ALIGN_BIT];
			s_reg.pend_sel <= 6'h00;
			s_reg.conv_sel <= 6'h00;
			s_reg.enable <= ACR_RESET_CONTROL[ACR_CTRL_ENABLE_BIT];
			s_reg.auto_trig <= ACR_RESET_CONTROL[ACR_CTRL_AUTO_BIT];
			s_reg.flag <= ACR_RESET_CONTROL[ACR_CTRL_FLAG_BIT];
			s_reg.irq_en <= ACR_RESET_CONTROL[ACR_CTRL_IRQ_EN_BIT];
			s_reg.div_code <= ACR_RESET_CONTROL[ACR_CTRL_DIV_MSB:ACR_CTRL_DIV_LSB];
			s_reg.trig_src <= ACR_RESET_CONTROL_B[ACR_TRIG_MSB:ACR_TRIG_LSB];
			s_reg.trig_prev <= 1'b0;
			s_reg.first_pending <= 1'b0;
			s_reg.presc <= 7'h00;
			s_reg.cycles_left <= 5'h00;
			s_reg.result <= ACR_RESET_RESULT;
			s_reg.locked <= 1'b0;
			s_reg.rdata <= ACR_READ_IDLE;
			s_reg.irq_req <= 1'b0;
			s_reg.sample <= 1'b0;
			s_reg.conv_tick <= 1'b0;
			s_reg.int_ref_on <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign RDATA_O = s_reg.rdata;
	assign IRQ_REQ_O = s_reg.irq_req;
	assign POWER_O = s_reg.enable;
	// only the busy code has its upper bit set, so no decode sits behind the pin
	assign BUSY_O = s_reg.phase[1];
	assign SAMPLE_O = s_reg.sample;
	assign CONV_TICK_O = s_reg.conv_tick;
	assign INT_REF_ON_O = s_reg.int_ref_on;
	assign REF_SEL_O = s_reg.conv_sel.ref_sel;
	assign CHAN_SEL_O = s_reg.conv_sel.chan_sel;

endmodule

// ===== logic/acr_pkg.sv
// Purpose: shared constants and types for the converter control and result block
// Assumes: byte-wide registers on a plain strobe port, one system clock
// Notes: offsets are the byte addresses of the register port

package acr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ACR_ADDR_RESULT_LOW = 8'h78;
	localparam logic [7:0] ACR_ADDR_RESULT_HIGH = 8'h79;
	localparam logic [7:0] ACR_ADDR_CONTROL = 8'h7a;
	localparam logic [7:0] ACR_ADDR_CONTROL_B = 8'h7b;
	localparam logic [7:0] ACR_ADDR_SELECT = 8'h7c;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACR_RESET_CONTROL = 8'h00;
	localparam logic [7:0] ACR_RESET_CONTROL_B = 8'h00;
	localparam logic [7:0] ACR_RESET_SELECT = 8'h00;
	localparam logic [9:0] ACR_RESET_RESULT = 10'h000;
	localparam logic [7:0] ACR_READ_IDLE = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ACR_CTRL_ENABLE_BIT = 7;
	localparam int ACR_CTRL_START_BIT = 6;
	localparam int ACR_CTRL_AUTO_BIT = 5;
	localparam int ACR_CTRL_FLAG_BIT = 4;
	localparam int ACR_CTRL_IRQ_EN_BIT = 3;
	localparam int ACR_CTRL_DIV_MSB = 2;
	localparam int ACR_CTRL_DIV_LSB = 0;
	localparam int ACR_SEL_REF_MSB = 7;
	localparam int ACR_SEL_REF_LSB = 6;
	localparam int ACR_SEL_ALIGN_BIT = 5;
	localparam int ACR_SEL_CHAN_MSB = 3;
	localparam int ACR_SEL_CHAN_LSB = 0;
	localparam int ACR_TRIG_MSB = 2;
	localparam int ACR_TRIG_LSB = 0;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] ACR_REF_EXTERNAL = 2'h0;
	localparam logic [1:0] ACR_REF_SUPPLY = 2'h1;
	localparam logic [1:0] ACR_REF_RESERVED = 2'h2;
	localparam logic [1:0] ACR_REF_INTERNAL = 2'h3;
	localparam logic [3:0] ACR_CHAN_LAST_INPUT = 4'h7;
	localparam logic [3:0] ACR_CHAN_BANDGAP = 4'he;
	localparam logic [3:0] ACR_CHAN_GROUND = 4'hf;
	localparam logic [2:0] ACR_TRIG_FREE_RUN = 3'h0;

	// ----------------------------------------------------------------
	// timing counts, in converter clock cycles and divider steps
	// ----------------------------------------------------------------
	localparam logic [4:0] ACR_FIRST_CYCLES = 5'h19;
	localparam logic [4:0] ACR_NORMAL_CYCLES = 5'h0d;
	localparam logic [4:0] ACR_LAST_CYCLE = 5'h01;
	localparam logic [2:0] ACR_DIV_MIN_SHIFT = 3'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ACR_OFF = 2'b00,
		ACR_IDLE = 2'b01,
		ACR_BUSY = 2'b10
	} acr_phase_t;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic [3:0] chan_sel;
	} acr_sel_t;

	typedef struct packed {
		acr_phase_t phase;
		acr_sel_t sel_reg;
		logic left_align;
		acr_sel_t pend_sel;
		acr_sel_t conv_sel;
		logic enable;
		logic auto_trig;
		logic flag;
		logic irq_en;
		logic [2:0] div_code;
		logic [2:0] trig_src;
		logic trig_prev;
		logic first_pending;
		logic [6:0] presc;
		logic [4:0] cycles_left;
		logic [9:0] result;
		logic locked;
		logic [7:0] rdata;
		logic irq_req;
		logic sample;
		logic conv_tick;
		logic int_ref_on;
	} acr_state_t;

endpackage

// ===== testbench/acr_core_model.sv
// Purpose: behavioural analog core that answers the converter control block
// Assumes: the code is taken in the cycle that SAMPLE_O pulses
// Notes: code is {channel, reference, 4'h5} so a test can predict it
`timescale 1ns/1ps
module acr_core_model
	import acr_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic SAMPLE_I,
	input wire logic BUSY_I,
	input wire logic [3:0] CHAN_I,
	input wire logic [1:0] REF_I,
	output logic [9:0] RESULT_O
);
	logic [9:0] held_reg;
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			held_reg <= 10'h000;
		end else if (SAMPLE_I) begin
			held_reg <= {CHAN_I, REF_I, 4'h5};
		end
	end
	// outside a conversion the core shows junk, never the last good code
	assign RESULT_O = BUSY_I ? held_reg : ~held_reg;
endmodule

// ===== testbench/acr_converter_chk.sv
// Purpose: port checks for the converter control block
// Assumes: one clock, reset active high
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module acr_converter_chk
	import acr_pkg::*;
#(
	parameter int RESULT_W = 10
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [RESULT_W-1:0] CORE_RESULT_I,
	input wire logic [6:0] TRIG_I,
	input wire logic GLOBAL_IRQ_EN_I,
	input wire logic IRQ_ACK_I,
	input wire logic [7:0] RDATA_O,
	input wire logic IRQ_REQ_O,
	input wire logic POWER_O,
	input wire logic BUSY_O,
	input wire logic SAMPLE_O,
	input wire logic CONV_TICK_O,
	input wire logic INT_REF_ON_O,
	input wire logic [1:0] REF_SEL_O,
	input wire logic [3:0] CHAN_SEL_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// --------------------------------------------------------------
	// converter clock count of the running conversion
	// --------------------------------------------------------------
	logic [4:0] tick_cnt;
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tick_cnt <= 5'h00;
		end else if (SAMPLE_O) begin
			tick_cnt <= 5'h00;
		end else if (CONV_TICK_O) begin
			tick_cnt <= tick_cnt + 5'h01;
		end
	end
	a_read_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data not zero outside read answer");
	a_irq_needs_global: assert property (IRQ_REQ_O |-> $past(GLOBAL_IRQ_EN_I))
		else $error("interrupt without global enable");
	a_busy_needs_power: assert property (BUSY_O |-> POWER_O)
		else $error("conversion running while off");
	a_start_samples: assert property ($rose(BUSY_O) |-> SAMPLE_O)
		else $error("conversion began without sample pulse");
	a_sel_held_busy: assert property (BUSY_O && $past(BUSY_O) && !SAMPLE_O
		|-> $stable(CHAN_SEL_O) && $stable(REF_SEL_O))
		else $error("selection changed mid conversion");
	a_int_ref_code: assert property (INT_REF_ON_O == (POWER_O && REF_SEL_O == 2'h3))
		else $error("internal reference state wrong");
	a_tick_spacing: assert property (CONV_TICK_O |=> !CONV_TICK_O)
		else $error("converter clock faster than half rate");
	a_off_aborts: assert property ($fell(POWER_O) |-> !BUSY_O)
		else $error("conversion survived power off");
	// the last converter tick shows in the same cycle busy drops, not yet counted
	a_conv_length: assert property ($fell(BUSY_O) && POWER_O
		|-> CONV_TICK_O && (tick_cnt == 5'h0c || tick_cnt == 5'h18))
		else $error("conversion length not 13 or 25");
	c_conversion: cover property ($fell(BUSY_O) && POWER_O);
	c_irq: cover property ($rose(IRQ_REQ_O));
	c_trigger: cover property (TRIG_I != 7'h00 && $rose(BUSY_O));
endmodule
bind acr_converter_ctrl acr_converter_chk #(.RESULT_W(RESULT_W)) u_acr_converter_chk (
	.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
	.RD_I(RD_I), .CORE_RESULT_I(CORE_RESULT_I), .TRIG_I(TRIG_I), .IRQ_ACK_I(IRQ_ACK_I),
	.GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .RDATA_O(RDATA_O), .IRQ_REQ_O(IRQ_REQ_O),
	.POWER_O(POWER_O), .BUSY_O(BUSY_O), .SAMPLE_O(SAMPLE_O), .CONV_TICK_O(CONV_TICK_O),
	.INT_REF_ON_O(INT_REF_ON_O), .REF_SEL_O(REF_SEL_O), .CHAN_SEL_O(CHAN_SEL_O));

// ===== testbench/test_adc_control_and_result_regs.sv
// Purpose: self-checking bench for the converter control block
// Assumes: core model gives {channel, reference, 4'h5}
// Notes: 40 MHz clock, strobe port driven by nonblocking writes
`timescale 1ns/1ps
module test_adc_control_and_result_regs;
	import acr_pkg::*;
	logic clk = 1'b0;
	logic rst, wr, rd, g_ie, ack, irq, pwr, busy, smp, tick, iref;
	logic [7:0] addr, wdata, rdata;
	logic [6:0] trig;
	logic [1:0] rsel;
	logic [3:0] csel;
	logic [9:0] core;
	int failures = 0;
	int samples_checked = 0;
	int n;
	always #12.5 clk = ~clk;
	acr_converter_ctrl u_acr_converter_ctrl (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .CORE_RESULT_I(core), .TRIG_I(trig),
		.GLOBAL_IRQ_EN_I(g_ie), .IRQ_ACK_I(ack), .RDATA_O(rdata), .IRQ_REQ_O(irq),
		.POWER_O(pwr), .BUSY_O(busy), .SAMPLE_O(smp), .CONV_TICK_O(tick),
		.INT_REF_ON_O(iref), .REF_SEL_O(rsel), .CHAN_SEL_O(csel));
	acr_core_model u_acr_core_model (.CLK_I(clk), .RESET_I(rst), .SAMPLE_I(smp),
		.BUSY_I(busy), .CHAN_I(csel), .REF_I(rsel), .RESULT_O(core));
	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic test_done();
		$display("mismatches %0d of %0d checks", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic bad, input string msg);
		samples_checked++;
		if (bad !== 1'b0) begin
			failures++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata !== e, $sformatf("read %h gave %h not %h", a, rdata, e));
	endtask
	// cycles from the start edge until busy drops
	task automatic wait_idle(output int cnt);
		cnt = 0;
		while (busy === 1'b1 && cnt < 6000) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (cnt >= 6000) begin
			failures++;
			test_done();
		end
	endtask
	// waits for the next sample pulse, skipping one already showing
	task automatic wait_sample();
		int cnt;
		cnt = 0;
		@(posedge clk);
		#1;
		while (smp !== 1'b1 && cnt < 60) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (cnt >= 60) begin
			failures++;
			test_done();
		end
	endtask
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 6; i++) begin
			rd_chk(8'h78 + 8'(i), 8'h00);
		end
	endtask
	task automatic t_single();
		wr_reg(ACR_ADDR_SELECT, 8'h53);
		rd_chk(ACR_ADDR_SELECT, 8'h43);
		wr_reg(ACR_ADDR_CONTROL, 8'hc8);
		wait_idle(n);
		check(n != 50, "first conversion length");
		rd_chk(ACR_ADDR_CONTROL, 8'h98);
		check(irq !== 1'b1, "interrupt missing");
		@(posedge clk);
		g_ie <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(irq !== 1'b0, "interrupt without global enable");
		@(posedge clk);
		g_ie <= 1'b1;
		check({rsel, csel} !== 6'h13, "applied selection");
		rd_chk(ACR_ADDR_RESULT_LOW, 8'hd5);
		rd_chk(ACR_ADDR_RESULT_HIGH, 8'h00);
		wr_reg(ACR_ADDR_CONTROL, 8'h98);
		rd_chk(ACR_ADDR_CONTROL, 8'h88);
	endtask
	task automatic t_align_lock();
		wr_reg(ACR_ADDR_SELECT, 8'h63);
		rd_chk(ACR_ADDR_RESULT_LOW, 8'h40);
		rd_chk(ACR_ADDR_RESULT_HIGH, 8'h35);
		wr_reg(ACR_ADDR_SELECT, 8'h45);
		rd_chk(ACR_ADDR_RESULT_LOW, 8'hd5);
		wr_reg(ACR_ADDR_CONTROL, 8'hca);
		wait_idle(n);
		check(n != 52, "later conversion length");
		rd_chk(ACR_ADDR_RESULT_HIGH, 8'h00);
		wr_reg(ACR_ADDR_CONTROL, 8'hca);
		wr_reg(ACR_ADDR_SELECT, 8'h47);
		check(csel !== 4'h5, "channel changed mid conversion");
		wait_idle(n);
		repeat (2) @(posedge clk);
		#1;
		check(csel !== 4'h7, "channel not applied after completion");
		rd_chk(ACR_ADDR_RESULT_LOW, 8'h55);
		rd_chk(ACR_ADDR_RESULT_HIGH, 8'h01);
	endtask
	task automatic t_abort();
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		rd_chk(ACR_ADDR_CONTROL, 8'h8a);
		wr_reg(ACR_ADDR_CONTROL, 8'hca);
		repeat (5) @(posedge clk);
		wr_reg(ACR_ADDR_CONTROL, 8'h00);
		check(busy !== 1'b0 || pwr !== 1'b0, "abort left converter on");
		repeat (120) @(posedge clk);
		rd_chk(ACR_ADDR_CONTROL, 8'h00);
	endtask
	task automatic t_trigger();
		wr_reg(ACR_ADDR_CONTROL_B, 8'h02);
		rd_chk(ACR_ADDR_CONTROL_B, 8'h02);
		wr_reg(ACR_ADDR_CONTROL, 8'ha0);
		@(posedge clk);
		trig <= 7'h02;
		n = 0;
		while (busy !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(busy !== 1'b1, "trigger edge did not start");
		wait_idle(n);
		check(n != 50, "triggered first conversion length");
		@(posedge clk);
		trig <= 7'h00;
		rd_chk(ACR_ADDR_CONTROL, 8'hb0);
		wr_reg(ACR_ADDR_CONTROL_B, 8'h00);
		wr_reg(ACR_ADDR_SELECT, 8'hc7);
		check(busy !== 1'b0, "free running source fired a start");
		check(iref !== 1'b1, "internal reference not on");
		wr_reg(ACR_ADDR_CONTROL, 8'hf0);
		wr_reg(ACR_ADDR_SELECT, 8'hc2);
		wait_sample();
		check(csel !== 4'h7, "second free running conversion changed channel");
		wait_sample();
		check(csel !== 4'h2, "third free running conversion kept old channel");
		repeat (100) @(posedge clk);
		#1;
		check(busy !== 1'b1, "free running stopped");
		rd_chk(ACR_ADDR_CONTROL, 8'hf0);
		wr_reg(ACR_ADDR_CONTROL, 8'h00);
		check(iref !== 1'b0 || pwr !== 1'b0, "off left reference on");
	endtask
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		ack = 1'b0;
		g_ie = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		trig = 7'h00;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_single();
		t_align_lock();
		t_abort();
		t_trigger();
		test_done();
	end
endmodule
